/* design/tlrbm_pkg.sv */
// Constants, tables and types of the thermal limit rod block monitor
//**************************************************************
//**************************************************************
package tlrbm_pkg;
    localparam int NUM_REGIONS = 48;
    localparam int NUM_CORNERS = 4;
    localparam int NUM_LEVELS = 4;
    localparam int NUM_SEGS = NUM_LEVELS + 1;
    localparam int NUM_DET = NUM_REGIONS * NUM_CORNERS * NUM_LEVELS;
    localparam int NUM_LHR = NUM_REGIONS * NUM_LEVELS;
    localparam logic [2:0] SEG_RATIO = 3'h4;
    localparam logic [1:0] LEVEL_B = 2'h1;
    localparam logic [1:0] LEVEL_D = 2'h3;
    localparam logic [5:0] LAST_REGION = 6'h2F;
    // Q8.8 fixed point: 16'h0100 is one
    localparam int FRAC_BITS = 8;
    localparam int DIV_BITS = 48;
    localparam logic [5:0] DIV_LAST = 6'h2F;
    localparam longint CLK_HZ = 40000000;
    localparam longint CYCLE_MS = 100;
    localparam int CYCLE_CLKS_DEF = int'(CLK_HZ / 1000 * CYCLE_MS);
    localparam logic [15:0] POWER_DELTA_LIMIT = 16'h0500;
    localparam logic [15:0] FLOW_DELTA_LIMIT = 16'h0500;
    localparam logic [15:0] FLOW_ADJ = 16'h00F0;
    localparam logic [15:0] ROD_ADJ = 16'h00E8;
    localparam logic [15:0] SETPOINT_MAX = 16'hFFFF;
    // Tables indexed by the top two bits of their input
    localparam logic [3:0][15:0] CPR_MARGIN_TBL = {16'h0110, 16'h0118, 16'h0120, 16'h0128};
    localparam logic [3:0][15:0] CPR_LIMIT_TBL = {16'h0160, 16'h0150, 16'h0140, 16'h0130};
    localparam logic [3:0][15:0] OFF_RATED_TBL = {16'h0100, 16'h0108, 16'h0110, 16'h0120};
    localparam logic [3:0][15:0] LVL_MARGIN_TBL = {16'h0118, 16'h0120, 16'h0128, 16'h0130};
    localparam logic [3:0][15:0] LVL_POS_TRIM = {16'h0000, 16'h0004, 16'h0008, 16'h000C};

    typedef enum logic [1:0] {TLRBM_DL_DET, TLRBM_DL_RATIO, TLRBM_DL_PLANAR} tlrbm_dl_kind_t;

    typedef struct packed {
        logic valid;
        logic done;
        tlrbm_dl_kind_t kind;
        logic [5:0] region;
        logic [1:0] corner;
        logic [1:0] level;
        logic [15:0] value;
    } tlrbm_dl_t;

    typedef struct packed {
        logic valid;
        logic [5:0] region;
        logic [1:0] corner;
        logic [1:0] level;
        logic [15:0] value;
    } tlrbm_rd_t;

    typedef struct packed {
        logic [15:0] power;
        logic [15:0] flow;
        logic [15:0] rod_pull;
        logic [15:0] rod_pos;
        logic flow_changing;
        logic adj_rods_moving;
    } tlrbm_plant_t;
endpackage : tlrbm_pkg

/* design/tlrbm_monitor.sv */
// Thermal limit rod block monitor: setpoint calculation, compare and trip
`timescale 1ns/1ps
module tlrbm_monitor #(
    parameter int CYCLE_CLKS = tlrbm_pkg::CYCLE_CLKS_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire tlrbm_pkg::tlrbm_plant_t PLANT,
    input wire tlrbm_pkg::tlrbm_rd_t READING,
    input wire tlrbm_pkg::tlrbm_dl_t DOWNLOAD,
    input wire logic MANUAL_REQ,
    output logic DOWNLOAD_REQ,
    output logic ROD_BLOCK,
    output logic FLOW_BLOCK,
    output logic READY,
    output logic CYCLE_DONE
);
    import tlrbm_pkg::*;

    //**************************************************************
    // Functions
    //**************************************************************
    function automatic logic [9:0] det_idx(input logic [5:0] r, input logic [1:0] c,
                                           input logic [1:0] l);
        det_idx = {r, c, l};
    endfunction : det_idx

    function automatic logic [15:0] avg4(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] c, input logic [15:0] d);
        logic [17:0] s;
        s = {2'h0, a} + {2'h0, b} + {2'h0, c} + {2'h0, d};
        avg4 = s[17:2];
    endfunction : avg4

    function automatic logic [15:0] qmul(input logic [15:0] a, input logic [15:0] f);
        logic [31:0] p;
        p = a * f;
        qmul = (p[31:24] != 8'h00) ? SETPOINT_MAX : p[23:8];
    endfunction : qmul

    function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
        abs_diff = (a > b) ? a - b : b - a;
    endfunction : abs_diff

    //**************************************************************
    // Storage
    //**************************************************************
    // Live and initial detectors are kept per region corner, so shared strings repeat
    logic [15:0] live_det [NUM_DET];
    logic [15:0] init_det [NUM_DET];
    logic [15:0] init_ratio [NUM_REGIONS];
    logic [15:0] init_planar [NUM_LHR];
    logic [15:0] sp_ratio [NUM_REGIONS];
    logic [15:0] sp_level [NUM_LHR];

    always_ff @(posedge CLK)
    begin
        if (READING.valid)
        begin
            live_det[det_idx(READING.region, READING.corner, READING.level)] <= READING.value;
        end
        if (DOWNLOAD.valid)
        begin
            case (DOWNLOAD.kind)
                TLRBM_DL_DET:
                    init_det[det_idx(DOWNLOAD.region, DOWNLOAD.corner, DOWNLOAD.level)]
                        <= DOWNLOAD.value;
                TLRBM_DL_RATIO:
                    init_ratio[DOWNLOAD.region] <= DOWNLOAD.value;
                TLRBM_DL_PLANAR:
                    init_planar[{DOWNLOAD.region, DOWNLOAD.level}] <= DOWNLOAD.value;
                default:
                    ;
            endcase
        end
    end

    //**************************************************************
    // Cycle timer and download request
    //**************************************************************
    logic [22:0] tick_cnt;
    logic [22:0] next_tick_cnt;
    logic tick;
    logic dl_req;
    logic next_dl_req;
    logic dl_busy;
    logic next_dl_busy;
    logic ready;
    logic next_ready;
    logic [15:0] ref_power;
    logic [15:0] next_ref_power;
    logic [15:0] ref_flow;
    logic [15:0] next_ref_flow;
    logic change_big;

    always_comb
    begin
        tick = (tick_cnt == 23'(CYCLE_CLKS - 1));
        next_tick_cnt = tick ? 23'h0 : tick_cnt + 23'h1;
        change_big = ready && ((abs_diff(PLANT.power, ref_power) > POWER_DELTA_LIMIT) ||
                               (abs_diff(PLANT.flow, ref_flow) > FLOW_DELTA_LIMIT));
        next_dl_req = dl_req;
        next_dl_busy = dl_busy;
        next_ready = ready;
        next_ref_power = ref_power;
        next_ref_flow = ref_flow;
        if (DOWNLOAD.valid)
        begin
            next_dl_busy = 1'b1;
        end
        if (DOWNLOAD.valid && DOWNLOAD.done)
        begin
            next_dl_req = 1'b0;
            next_dl_busy = 1'b0;
            next_ready = 1'b1;
            next_ref_power = PLANT.power;
            next_ref_flow = PLANT.flow;
        end
        // A new cause in the clearing cycle still raises the request
        if (change_big || MANUAL_REQ)
        begin
            next_dl_req = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            tick_cnt <= 23'h0;
            dl_req <= 1'b0;
            dl_busy <= 1'b0;
            ready <= 1'b0;
            ref_power <= 16'h0;
            ref_flow <= 16'h0;
        end
        else
        begin
            tick_cnt <= next_tick_cnt;
            dl_req <= next_dl_req;
            dl_busy <= next_dl_busy;
            ready <= next_ready;
            ref_power <= next_ref_power;
            ref_flow <= next_ref_flow;
        end
    end

    //**************************************************************
    // Setpoint sequencer
    //**************************************************************
    typedef enum {S_IDLE, S_LOAD, S_DIV, S_STORE} tlrbm_state_t;

    tlrbm_state_t state;
    tlrbm_state_t next_state;
    logic [5:0] region;
    logic [5:0] next_region;
    logic [2:0] seg;
    logic [2:0] next_seg;
    logic [5:0] div_cnt;
    logic [5:0] next_div_cnt;
    logic [DIV_BITS-1:0] quot;
    logic [DIV_BITS-1:0] next_quot;
    logic [16:0] rem;
    logic [16:0] next_rem;
    logic [15:0] divisor;
    logic [15:0] next_divisor;
    logic trip;
    logic next_trip;
    logic exceed_acc;
    logic next_exceed_acc;
    logic done_pulse;
    logic next_done_pulse;
    logic [15:0] init_avg [NUM_LEVELS];
    logic [15:0] live_avg [NUM_LEVELS];
    logic [17:0] init_sum;
    logic [17:0] live_sum;
    logic [15:0] fac_a;
    logic [15:0] fac_b;
    logic [15:0] num_pow;
    logic [15:0] sp_raw;
    logic [15:0] sp_final;
    logic [17:0] live_val;
    logic [16:0] rem_sh;
    logic store_en;

    always_comb
    begin
        init_sum = 18'h0;
        live_sum = 18'h0;
        for (int l = 0; l < NUM_LEVELS; l++)
        begin
            init_avg[l] = avg4(init_det[det_idx(region, 2'h0, 2'(l))],
                               init_det[det_idx(region, 2'h1, 2'(l))],
                               init_det[det_idx(region, 2'h2, 2'(l))],
                               init_det[det_idx(region, 2'h3, 2'(l))]);
            live_avg[l] = avg4(live_det[det_idx(region, 2'h0, 2'(l))],
                               live_det[det_idx(region, 2'h1, 2'(l))],
                               live_det[det_idx(region, 2'h2, 2'(l))],
                               live_det[det_idx(region, 2'h3, 2'(l))]);
            if (2'(l) >= LEVEL_B && 2'(l) <= LEVEL_D)
            begin
                init_sum = init_sum + {2'h0, init_avg[l]};
                live_sum = live_sum + {2'h0, live_avg[l]};
            end
        end
        if (seg == SEG_RATIO)
        begin
            num_pow = (init_sum[17:16] != 2'h0) ? SETPOINT_MAX : init_sum[15:0];
            fac_a = CPR_MARGIN_TBL[PLANT.rod_pull[15:14]];
            fac_b = init_ratio[region];
            live_val = live_sum;
        end
        else
        begin
            num_pow = init_avg[seg[1:0]];
            fac_a = LVL_MARGIN_TBL[PLANT.power[15:14]]
                    + LVL_POS_TRIM[PLANT.rod_pos[15:14]] + {14'h0, seg[1:0]};
            fac_b = OFF_RATED_TBL[PLANT.power[15:14]];
            live_val = {2'h0, live_avg[seg[1:0]]};
        end
    end

    always_comb
    begin
        sp_raw = (quot[DIV_BITS-1:16] != 32'h0) ? SETPOINT_MAX : quot[15:0];
        sp_final = sp_raw;
        if (seg == SEG_RATIO && PLANT.flow_changing)
        begin
            sp_final = qmul(sp_final, FLOW_ADJ);
        end
        if (seg == SEG_RATIO && PLANT.adj_rods_moving)
        begin
            sp_final = qmul(sp_final, ROD_ADJ);
        end
        rem_sh = {rem[15:0], quot[DIV_BITS-1]};
        store_en = (state == S_STORE);
    end

    always_comb
    begin
        next_state = state;
        next_region = region;
        next_seg = seg;
        next_div_cnt = div_cnt;
        next_quot = quot;
        next_rem = rem;
        next_divisor = divisor;
        next_trip = trip;
        next_exceed_acc = exceed_acc;
        next_done_pulse = 1'b0;
        case (state)
            S_IDLE:
            begin
                // No new pass starts while a download is in flight; a pass already running still stores setpoints and sets trip
                if (tick && ready && !dl_busy)
                begin
                    next_region = 6'h0;
                    next_seg = 3'h0;
                    next_exceed_acc = 1'b0;
                    next_state = S_LOAD;
                end
            end
            S_LOAD:
            begin
                next_quot = ({32'h0, num_pow} * {32'h0, fac_a} * {32'h0, fac_b})
                            >> FRAC_BITS;
                if (seg == SEG_RATIO)
                begin
                    next_divisor = CPR_LIMIT_TBL[PLANT.power[15:14]];
                end
                else
                begin
                    next_divisor = init_planar[{region, seg[1:0]}];
                end
                next_rem = 17'h0;
                next_div_cnt = 6'h0;
                next_state = S_DIV;
            end
            S_DIV:
            begin
                // Bit-serial divide keeps one small divider for all 240 setpoints
                if (rem_sh >= {1'b0, divisor})
                begin
                    next_rem = rem_sh - {1'b0, divisor};
                    next_quot = {quot[DIV_BITS-2:0], 1'b1};
                end
                else
                begin
                    next_rem = rem_sh;
                    next_quot = {quot[DIV_BITS-2:0], 1'b0};
                end
                if (divisor == 16'h0)
                begin
                    next_quot = '1;
                end
                next_div_cnt = div_cnt + 6'h1;
                if (div_cnt == DIV_LAST)
                begin
                    next_state = S_STORE;
                end
            end
            S_STORE:
            begin
                if (live_val > {2'h0, sp_final})
                begin
                    next_exceed_acc = 1'b1;
                    next_trip = 1'b1;
                end
                next_state = S_LOAD;
                if (seg == SEG_RATIO)
                begin
                    next_seg = 3'h0;
                    next_region = region + 6'h1;
                    if (region == LAST_REGION)
                    begin
                        next_trip = next_exceed_acc;
                        next_done_pulse = 1'b1;
                        next_state = S_IDLE;
                    end
                end
                else
                begin
                    next_seg = seg + 3'h1;
                end
            end
            default:
                next_state = S_IDLE;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (store_en)
        begin
            if (seg == SEG_RATIO)
            begin
                sp_ratio[region] <= sp_final;
            end
            else
            begin
                sp_level[{region, seg[1:0]}] <= sp_final;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state <= S_IDLE;
            region <= 6'h0;
            seg <= 3'h0;
            div_cnt <= 6'h0;
            quot <= '0;
            rem <= 17'h0;
            divisor <= 16'h0;
            trip <= 1'b0;
            exceed_acc <= 1'b0;
            done_pulse <= 1'b0;
        end
        else
        begin
            state <= next_state;
            region <= next_region;
            seg <= next_seg;
            div_cnt <= next_div_cnt;
            quot <= next_quot;
            rem <= next_rem;
            divisor <= next_divisor;
            trip <= next_trip;
            exceed_acc <= next_exceed_acc;
            done_pulse <= next_done_pulse;
        end
    end

    //**************************************************************
    // Outputs
    //**************************************************************
    assign ROD_BLOCK = trip;
    assign FLOW_BLOCK = trip;
    assign DOWNLOAD_REQ = dl_req;
    assign READY = ready;
    assign CYCLE_DONE = done_pulse;
endmodule : tlrbm_monitor

/* verification/tlrbm_checker.sv */
// Port assertions of the thermal limit rod block monitor
`timescale 1ns/1ps
module tlrbm_checker #(
    parameter int CYCLE_CLKS = tlrbm_pkg::CYCLE_CLKS_DEF
) (
    input wire logic CLK,
    input wire logic RST,
    input wire tlrbm_pkg::tlrbm_plant_t PLANT,
    input wire tlrbm_pkg::tlrbm_rd_t READING,
    input wire tlrbm_pkg::tlrbm_dl_t DOWNLOAD,
    input wire logic MANUAL_REQ,
    input wire logic DOWNLOAD_REQ,
    input wire logic ROD_BLOCK,
    input wire logic FLOW_BLOCK,
    input wire logic READY,
    input wire logic CYCLE_DONE
);
    import tlrbm_pkg::*;
    //**********
    // Pass spacing counter, saturates so the first pass never fails
    //**********
    logic [13:0] gap;
    logic [13:0] next_gap;
    always_comb next_gap = CYCLE_DONE ? 14'h0000 : ((gap == 14'h3FFF) ? gap : gap + 14'h0001);
    always_ff @(posedge CLK or posedge RST)
        if (RST)
            gap <= 14'h3FFF;
        else
            gap <= next_gap;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    chk_blocks_tied: assert property (ROD_BLOCK == FLOW_BLOCK)
        else $error("rod block and flow block differ");
    chk_manual_request: assert property (MANUAL_REQ |=> DOWNLOAD_REQ)
        else $error("manual request not raised");
    chk_done_ready: assert property (DOWNLOAD.valid && DOWNLOAD.done |=> READY)
        else $error("ready missing after last word");
    chk_done_clears: assert property (DOWNLOAD.valid && DOWNLOAD.done && !MANUAL_REQ && !READY
        |=> !DOWNLOAD_REQ)
        else $error("request stayed after last word");
    chk_pulse_single: assert property (CYCLE_DONE |=> !CYCLE_DONE)
        else $error("pass end pulse too long");
    chk_pass_length: assert property (CYCLE_DONE |-> gap >= 14'h2EE0)
        else $error("pass shorter than all setpoints");
    chk_pass_ready: assert property (!READY |-> !CYCLE_DONE)
        else $error("pass without downloaded values");
    chk_request_cause: assert property ($rose(DOWNLOAD_REQ) |-> $past(MANUAL_REQ) || READY)
        else $error("request without cause");
    chk_trip_clear: assert property ($fell(ROD_BLOCK) |-> CYCLE_DONE)
        else $error("trip cleared outside pass end");
    cov_trip: cover property ($rose(ROD_BLOCK));
    cov_pass: cover property (CYCLE_DONE);
    cov_last_word: cover property (DOWNLOAD.valid && DOWNLOAD.done);
endmodule : tlrbm_checker

bind tlrbm_monitor tlrbm_checker #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (.CLK(CLK), .RST(RST),
    .PLANT(PLANT), .READING(READING), .DOWNLOAD(DOWNLOAD), .MANUAL_REQ(MANUAL_REQ),
    .DOWNLOAD_REQ(DOWNLOAD_REQ), .ROD_BLOCK(ROD_BLOCK), .FLOW_BLOCK(FLOW_BLOCK),
    .READY(READY), .CYCLE_DONE(CYCLE_DONE));

/* verification/tlrbm_partner.sv */
// Plant computer model that answers download requests
`timescale 1ns/1ps
module tlrbm_partner (
    input wire logic clk,
    input wire logic rst,
    input wire logic download_req,
    input wire logic slow,
    output tlrbm_pkg::tlrbm_dl_t dl
);
    import tlrbm_pkg::*;
    task automatic put(input logic [1:0] k, input logic [5:0] r, input logic [1:0] c,
        input logic [1:0] l, input logic [15:0] v, input logic last);
        dl = {1'b1, last, k, r, c, l, v};
        @(posedge clk);
        #2;
        if (slow || last)
        begin
            // Released word shows inverted data, never the stale value
            dl.valid = 1'b0;
            dl.value = ~dl.value;
            if (slow)
            begin
                @(posedge clk);
                #2;
            end
        end
    endtask : put
    task automatic send_all;
        for (int r = 0; r < NUM_REGIONS; r++)
            for (int i = 0; i < 16; i++)
                put(2'h0, 6'(r), 2'(i / 4), 2'(i % 4), 16'h0100, 1'b0);
        for (int r = 0; r < NUM_REGIONS; r++)
            put(2'h1, 6'(r), 2'h0, 2'h0, 16'h0130, 1'b0);
        for (int i = 0; i < NUM_LHR; i++)
            put(2'h2, 6'(i / 4), 2'h0, 2'(i % 4), 16'h0100, 1'(i == NUM_LHR - 1));
    endtask : send_all
    initial
    begin
        dl = '0;
        forever
        begin
            // Sample and drive off the edge so the first word never races the design
            @(posedge clk);
            #2;
            if (!rst && download_req)
                send_all();
        end
    end
endmodule : tlrbm_partner

/* verification/test_thermal_limit_rod_block_monitor.sv */
// Testbench of the thermal limit rod block monitor
`timescale 1ns/1ps
module test_thermal_limit_rod_block_monitor;
    import tlrbm_pkg::*;
    // Shortened cycle; a pass still needs 12000 clocks
    localparam int CYC = 13000;
    logic clk, rst, manual_req, slow;
    logic download_req, rod_block, flow_block, ready, cycle_done;
    tlrbm_plant_t plant;
    tlrbm_rd_t reading;
    tlrbm_dl_t download;
    int mismatches, n_tests, n;
    tlrbm_monitor #(.CYCLE_CLKS(CYC)) dut (.CLK(clk), .RST(rst), .PLANT(plant),
        .READING(reading), .DOWNLOAD(download), .MANUAL_REQ(manual_req),
        .DOWNLOAD_REQ(download_req), .ROD_BLOCK(rod_block), .FLOW_BLOCK(flow_block),
        .READY(ready), .CYCLE_DONE(cycle_done));
    tlrbm_partner predictor (.clk(clk), .rst(rst), .download_req(download_req), .slow(slow),
        .dl(download));
    //**********
    // Shared tasks
    //**********
    task automatic chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic step;
        @(posedge clk);
        #2;
    endtask : step
    task automatic put_rd(input logic [5:0] r, input logic [1:0] c, input logic [1:0] l,
        input logic [15:0] v);
        reading = {1'b1, r, c, l, v};
        step;
    endtask : put_rd
    // Release only after the last strobe, so back-to-back writes assign once per step
    task automatic rd_idle;
        reading.valid = 1'b0;
        reading.value = ~reading.value;
    endtask : rd_idle
    task automatic wait_pass;
        n = 0;
        do
        begin
            step;
            n++;
        end while (cycle_done !== 1'b1 && n < 30000);
        chk(cycle_done === 1'b1, "no pass end");
    endtask : wait_pass
    task automatic end_sim;
        $display("Checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    //**********
    // Scenarios
    //**********
    task automatic t_download;
        for (int i = 0; i < NUM_DET; i++)
            put_rd(6'(i / 16), 2'((i / 4) % 4), 2'(i % 4), 16'h0010);
        rd_idle;
        chk(download_req === 1'b0 && ready === 1'b0, "request before cause");
        manual_req = 1'b1;
        step;
        manual_req = 1'b0;
        chk(download_req === 1'b1, "manual request ignored");
        n = 0;
        while (download_req === 1'b1 && n < 3000)
        begin
            step;
            n++;
        end
        chk(download_req === 1'b0 && ready === 1'b1, "download not taken");
    endtask : t_download
    task automatic t_level;
        wait_pass;
        chk(rod_block === 1'b0, "trip on low readings");
        // Last region, last corner and level: the boundary of the pass order
        put_rd(6'h2F, 2'h3, 2'h3, 16'h0800);
        rd_idle;
        wait_pass;
        chk(n + 1 == CYC, "pass spacing wrong");
        chk(rod_block === 1'b1 && flow_block === 1'b1, "level overrun missed");
    endtask : t_level
    task automatic t_ratio(input logic [15:0] v, input logic fc, input logic exp);
        put_rd(6'h2F, 2'h3, 2'h3, 16'h0010);
        for (int l = 1; l < 4; l++)
            put_rd(6'h0A, 2'h0, 2'(l), v);
        rd_idle;
        plant.flow_changing = fc;
        wait_pass;
        chk(rod_block === exp && flow_block === exp, "ratio trip wrong");
    endtask : t_ratio
    task automatic t_power;
        plant.flow_changing = 1'b0;
        slow = 1'b1;
        plant.power = 16'h0600;
        n = 0;
        while (download_req !== 1'b1 && n < 4)
        begin
            step;
            n++;
        end
        chk(download_req === 1'b1, "power step ignored");
        n = 0;
        while (download_req === 1'b1 && n < 5000)
        begin
            step;
            n++;
        end
        chk(download_req === 1'b0 && rod_block === 1'b1, "trip not held");
    endtask : t_power
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim;
    end
    initial
    begin
        rst = 1'b1;
        plant = '0;
        reading = '0;
        manual_req = 1'b0;
        slow = 1'b0;
        repeat (10) @(posedge clk);
        #2;
        rst = 1'b0;
        t_download;
        t_level;
        t_ratio(16'h0430, 1'b0, 1'b0);
        t_ratio(16'h0490, 1'b0, 1'b1);
        t_ratio(16'h0430, 1'b1, 1'b1);
        t_power;
        end_sim;
    end
endmodule : test_thermal_limit_rod_block_monitor
